// ===== design/dsg_pkg.sv
// Contract
// - Trigger select bits 5:2, codes 1-11, reset zero
// - Setting bit 6 empties trace buffer
// - Trace data readable only through side port
// - Capability ID reads constant 0Dh
// - Next pointer read-only, resets to C0h
// - Vendor identifier read-only, side port writable
// - Device identifier read-only, side port writable
// - Bit 0 reflects sampled pin 0 level
// - Direction bit: 0 input, 1 output, reset 0
// - Output value driven while direction is output
// - Each pin uses a four-bit group
// - Pin control register only in upstream port
`default_nettype none
package dsg_pkg;
  localparam logic [7:0]  OFS_TRACE_CTRL = 8'h9C;
  localparam logic [7:0]  OFS_TRACE_OUT  = 8'hAC;
  localparam logic [7:0]  OFS_CAP_HDR    = 8'hB0;
  localparam logic [7:0]  OFS_SUBSYS_ID  = 8'hB4;
  localparam logic [7:0]  OFS_PIN_CTRL   = 8'hB8;
  localparam int          PORT_SEL_LSB   = 0;
  localparam int          TRIG_LSB       = 2;
  localparam int          CLEAR_BIT      = 6;
  localparam logic [3:0]  TRIG_MAX       = 4'hB;
  localparam logic [7:0]  CAP_ID         = 8'h0D;
  localparam logic [7:0]  NEXT_PTR_RST   = 8'hC0;
  localparam logic [15:0] VENDOR_ID_RST  = 16'h1234; // Value is arbitrary
  localparam logic [15:0] DEVICE_ID_RST  = 16'h5678; // Value is arbitrary
  localparam int          PIN_IN_BIT     = 0;
  localparam int          PIN_DIR_BIT    = 1;
  localparam int          PIN_OUT_BIT    = 2;
  localparam int          PIN_GROUP      = 4;
endpackage : dsg_pkg
`default_nettype wire

// ===== design/dsg_regs.sv
`timescale 1ns/1ns
`default_nettype none
module dsg_regs #(
  parameter int          NUM_PINS    = 8,
  parameter logic        IS_UPSTREAM = 1'b1
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire logic                   cfg_wr,
  input  wire logic                   cfg_rd,
  input  wire logic [7:0]             cfg_addr,
  input  wire logic [31:0]            cfg_wdata,
  output logic      [31:0]            cfg_rdata,
  input  wire logic                   sm_wr,
  input  wire logic                   sm_rd,
  input  wire logic [7:0]             sm_addr,
  input  wire logic [31:0]            sm_wdata,
  output logic      [31:0]            sm_rdata,
  input  wire logic [31:0]            trace_data,
  output logic                        trace_clear,
  output logic      [3:0]             trigger_sel,
  output logic      [1:0]             debug_port_sel,
  input  wire logic [NUM_PINS-1:0]    pin_i,
  output logic      [NUM_PINS-1:0]    pin_o,
  output logic      [NUM_PINS-1:0]    pin_oe
);
  import dsg_pkg::*;

  logic [1:0]          port_sel_r;
  logic [3:0]          trig_r;
  logic                clear_r;
  logic [15:0]         vendor_r;
  logic [15:0]         device_r;
  logic [NUM_PINS-1:0] dir_r;
  logic [NUM_PINS-1:0] outv_r;
  logic [NUM_PINS-1:0] pin_s_r;
  logic                any_wr;
  logic [7:0]          wa;
  logic [31:0]         wd;
  logic [31:0]         pin_word;

  assign any_wr = cfg_wr | sm_wr;
  assign wa     = sm_wr ? sm_addr : cfg_addr;
  assign wd     = sm_wr ? sm_wdata : cfg_wdata;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port_sel_r <= 2'h0;
      trig_r     <= 4'h0;
    end else if (clk_en && any_wr && wa == OFS_TRACE_CTRL) begin
      port_sel_r <= wd[PORT_SEL_LSB+:2];
      trig_r     <= wd[TRIG_LSB+:4];
    end
  end

  trig_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && cfg_wr && !sm_wr && cfg_addr == OFS_TRACE_CTRL
    |=> trigger_sel == $past(cfg_wdata[TRIG_LSB+:4]))
    else $error("trigger select not written");
  port_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && cfg_wr && !sm_wr && cfg_addr == OFS_TRACE_CTRL
    |=> debug_port_sel == $past(cfg_wdata[PORT_SEL_LSB+:2]))
    else $error("port select not written");
  state_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clk_en |=> $stable(trigger_sel) && $stable(debug_port_sel) && $stable(pin_oe))
    else $error("state moved while clock enable low");

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clear_r <= 1'b0;
    end else if (clk_en) begin
      clear_r <= any_wr && wa == OFS_TRACE_CTRL && wd[CLEAR_BIT];
    end
  end

  clear_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !(any_wr && wa == OFS_TRACE_CTRL && wd[CLEAR_BIT]) |=> !trace_clear)
    else $error("trace clear pulsed without clear write");

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vendor_r <= VENDOR_ID_RST;
      device_r <= DEVICE_ID_RST;
    end else if (clk_en && sm_wr && sm_addr == OFS_SUBSYS_ID) begin
      vendor_r <= sm_wdata[15:0];
      device_r <= sm_wdata[31:16];
    end
  end

  id_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && sm_wr && sm_addr == OFS_SUBSYS_ID |=> {device_r, vendor_r} == $past(sm_wdata))
    else $error("identifier not loaded from side port");

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_r  <= '0;
      outv_r <= '0;
    end else if (clk_en && IS_UPSTREAM && any_wr && wa == OFS_PIN_CTRL) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        dir_r[i]  <= wd[PIN_GROUP*i+PIN_DIR_BIT];
        outv_r[i] <= wd[PIN_GROUP*i+PIN_OUT_BIT];
      end
    end
  end

  pin_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && IS_UPSTREAM && cfg_wr && !sm_wr && cfg_addr == OFS_PIN_CTRL
    |=> pin_oe[0] == $past(cfg_wdata[PIN_DIR_BIT]))
    else $error("pin 0 direction not written");
  pin_group_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && IS_UPSTREAM && cfg_wr && !sm_wr && cfg_addr == OFS_PIN_CTRL
    |=> pin_oe[3] == $past(cfg_wdata[PIN_GROUP*3+PIN_DIR_BIT])
    && pin_o[3] == ($past(cfg_wdata[PIN_GROUP*3+PIN_DIR_BIT])
    && $past(cfg_wdata[PIN_GROUP*3+PIN_OUT_BIT])))
    else $error("pin 3 group misplaced");
  pin_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(clk_en && any_wr) |=> $stable(pin_oe) && $stable(pin_o))
    else $error("pin drive changed without write");

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s_r <= '0;
    end else if (clk_en) begin
      pin_s_r <= pin_i;
    end
  end

  always_comb begin
    pin_word = 32'h0;
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_word[PIN_GROUP*i+PIN_IN_BIT]  = pin_s_r[i];
      pin_word[PIN_GROUP*i+PIN_DIR_BIT] = dir_r[i];
      pin_word[PIN_GROUP*i+PIN_OUT_BIT] = outv_r[i];
    end
  end

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic side);
    logic [31:0] v;
    v = 32'h0;
    if (a == OFS_TRACE_CTRL) begin
      v = {25'h0, 1'b0, trig_r, port_sel_r};
    end else if (a == OFS_TRACE_OUT) begin
      v = side ? trace_data : 32'h0;
    end else if (a == OFS_CAP_HDR) begin
      v = {16'h0, NEXT_PTR_RST, CAP_ID};
    end else if (a == OFS_SUBSYS_ID) begin
      v = {device_r, vendor_r};
    end else if (a == OFS_PIN_CTRL) begin
      v = IS_UPSTREAM ? pin_word : 32'h0;
    end
    return v;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h0;
      sm_rdata  <= 32'h0;
    end else if (clk_en) begin
      if (cfg_rd) begin
        cfg_rdata <= rd_mux(cfg_addr, 1'b0);
      end
      if (sm_rd) begin
        sm_rdata <= rd_mux(sm_addr, 1'b1);
      end
    end
  end

  cfg_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(clk_en && cfg_rd) |=> $stable(cfg_rdata))
    else $error("config read data moved without read");
  sm_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(clk_en && sm_rd) |=> $stable(sm_rdata))
    else $error("side read data moved without read");
  sm_hdr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && sm_rd && sm_addr == OFS_CAP_HDR |=> sm_rdata == {16'h0, NEXT_PTR_RST, CAP_ID})
    else $error("capability header wrong on side port");
  pin_rsvd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && cfg_rd && cfg_addr == OFS_PIN_CTRL |=> (cfg_rdata & 32'h88888888) == 32'h0)
    else $error("reserved pin bits not zero");

  assign pin_oe         = dir_r;
  assign pin_o          = dir_r & outv_r;
  assign trace_clear    = clear_r;
  assign trigger_sel    = trig_r;
  assign debug_port_sel = port_sel_r;

  trig_reset_a: assert property (@(posedge clk_sys) $rose(rst_n) |-> trig_r == 4'h0)
    else $error("trigger select not zero after reset");
  clear_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && cfg_wr && !sm_wr && cfg_addr == OFS_TRACE_CTRL && cfg_wdata[CLEAR_BIT]
    |=> trace_clear)
    else $error("clear write did not pulse trace clear");
  trace_hidden_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && cfg_rd && cfg_addr == OFS_TRACE_OUT |=> cfg_rdata == 32'h0)
    else $error("trace data leaked to config read");
  trace_side_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && sm_rd && sm_addr == OFS_TRACE_OUT |=> sm_rdata == $past(trace_data))
    else $error("trace data wrong on side port");
  cap_hdr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && cfg_rd && cfg_addr == OFS_CAP_HDR |=> cfg_rdata == 32'h0000C00D)
    else $error("capability header wrong");
  id_cfg_ro_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !sm_wr |=> $stable(vendor_r) && $stable(device_r))
    else $error("identifier changed without side write");
  pin_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && IS_UPSTREAM && cfg_wr && !sm_wr && cfg_addr == OFS_PIN_CTRL
    |=> pin_o[0] == ($past(cfg_wdata[PIN_DIR_BIT]) && $past(cfg_wdata[PIN_OUT_BIT])))
    else $error("pin drive mismatch");
  pin_sample_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && $past(clk_en) && sm_rd && sm_addr == OFS_PIN_CTRL
    |=> sm_rdata[PIN_IN_BIT] == $past(pin_i[0], 2))
    else $error("pin 0 state not reflected");
  dir_reset_a: assert property (@(posedge clk_sys) $rose(rst_n) |-> pin_oe == '0)
    else $error("pins not inputs after reset");
  rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && cfg_rd && cfg_addr == OFS_TRACE_CTRL |=> cfg_rdata[31:6] == 26'h0)
    else $error("reserved bits not zero");

  clear_c:  cover property (@(posedge clk_sys) disable iff (!rst_n) trace_clear);
  out_c:    cover property (@(posedge clk_sys) disable iff (!rst_n) pin_oe[3] && pin_o[3]);
  idwr_c:   cover property (@(posedge clk_sys) disable iff (!rst_n) sm_wr && sm_addr == OFS_SUBSYS_ID);
  trig_c:   cover property (@(posedge clk_sys) disable iff (!rst_n) trig_r == TRIG_MAX);
  freeze_c: cover property (@(posedge clk_sys) disable iff (!rst_n) !clk_en && cfg_wr);
endmodule // dsg_regs
`default_nettype wire

// ===== testbench/dsg_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module dsg_far_model #(
  parameter logic [7:0]  EXT_LEVEL  = 8'h5A,
  parameter logic [31:0] TRACE_FULL = 32'hA5C30F96
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        trace_clear,
  input  wire logic [7:0]  pin_o,
  input  wire logic [7:0]  pin_oe,
  output logic      [7:0]  pin_i,
  output logic      [31:0] trace_data
);
  // Driven pins loop back, others sit at board level
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & EXT_LEVEL);
  // Trace buffer empties on clear pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) trace_data <= TRACE_FULL;
    else if (trace_clear) trace_data <= 32'h0;
  end
endmodule // dsg_far_model
`default_nettype wire

// ===== testbench/test_debug_subsys_gpio_config_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_debug_subsys_gpio_config_regs;
  import dsg_pkg::*;
  localparam logic [7:0]  EXT = 8'h5A;
  localparam logic [31:0] TRC = 32'hA5C30F96;
  logic clk_sys, rst_n, clk_en, cfg_wr, cfg_rd, sm_wr, sm_rd, trace_clear;
  logic [7:0]  cfg_addr, sm_addr, pin_i, pin_o, pin_oe;
  logic [31:0] cfg_wdata, cfg_rdata, sm_wdata, sm_rdata, trace_data, e;
  logic [3:0]  trigger_sel;
  logic [1:0]  debug_port_sel;
  int          err_count, tests_run;
  dsg_regs u_dsg_regs (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .sm_wr(sm_wr), .sm_rd(sm_rd), .sm_addr(sm_addr), .sm_wdata(sm_wdata),
    .sm_rdata(sm_rdata), .trace_data(trace_data), .trace_clear(trace_clear),
    .trigger_sel(trigger_sel), .debug_port_sel(debug_port_sel), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe));
  dsg_far_model #(.EXT_LEVEL(EXT), .TRACE_FULL(TRC)) u_dsg_far_model (.clk_sys(clk_sys),
    .rst_n(rst_n), .trace_clear(trace_clear), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_i(pin_i), .trace_data(trace_data));
  task automatic acc(input logic s, input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    if (s) begin
      sm_wr <= w; sm_rd <= !w; sm_addr <= a; sm_wdata <= d;
    end else begin
      cfg_wr <= w; cfg_rd <= !w; cfg_addr <= a; cfg_wdata <= d;
    end
    @(posedge clk_sys);
    {sm_wr, sm_rd, cfg_wr, cfg_rd} <= 4'h0;
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic s, input logic [7:0] a, input logic [31:0] exp);
    acc(s, 1'b0, a, 32'h0);
    chk(s ? sm_rdata : cfg_rdata, exp);
  endtask
  task automatic conclude();
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    err_count++;
    conclude();
  end
  initial begin
    {rst_n, cfg_wr, cfg_rd, sm_wr, sm_rd, cfg_addr, sm_addr, cfg_wdata, sm_wdata} = '0;
    clk_en = 1'b1;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(0, 8'h9C, 32'h0);
    rd(0, 8'hB0, {16'h0, NEXT_PTR_RST, CAP_ID});
    rd(1, 8'hB0, {16'h0, NEXT_PTR_RST, CAP_ID});
    acc(0, 1, 8'hB0, 32'hFFFFFFFF);
    rd(0, 8'hB0, {16'h0, NEXT_PTR_RST, CAP_ID});
    acc(0, 1, 8'hB4, 32'hFFFFFFFF);
    rd(0, 8'hB4, {DEVICE_ID_RST, VENDOR_ID_RST});
    acc(1, 1, 8'hB4, 32'hBEEFCAFE);
    rd(1, 8'hB4, 32'hBEEFCAFE);
    rd(1, 8'hAC, TRC);
    rd(0, 8'hAC, 32'h0);
    acc(0, 1, 8'h9C, 32'hFFFFFFFF);
    chk({31'h0, trace_clear}, 32'h1);
    rd(0, 8'h9C, 32'h3F);
    chk({31'h0, trace_clear}, 32'h0);
    rd(1, 8'hAC, 32'h0);
    for (int c = 1; c <= 11; c++) begin
      acc(0, 1, 8'h9C, (32'(c) << 2) | 32'h1);
      chk({26'h0, debug_port_sel, trigger_sel}, {26'h0, 2'b01, 4'(c)});
    end
    @(posedge clk_sys);
    clk_en <= 1'b0;
    acc(0, 1, 8'h9C, 32'h0);
    chk({26'h0, debug_port_sel, trigger_sel}, 32'h1B);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: e = 32'h0;
        1: e = 32'h77777777;
        2: e = 32'h22222222;
        3: e = 32'hDDDDDDDD;
        default: e = 32'h00006420;
      endcase
      acc(0, 1, 8'hB8, e);
      for (int n = 0; n < 8; n++) begin
        e[4*n+3] = 1'b0;
        e[4*n] = e[4*n+1] ? e[4*n+2] : EXT[n];
      end
      @(posedge clk_sys);
      rd(0, 8'hB8, e);
      rd(1, 8'hB8, e);
      for (int n = 0; n < 8; n++) begin
        chk({30'h0, pin_oe[n], pin_o[n]}, {30'h0, e[4*n+1], e[4*n+1] & e[4*n+2]});
      end
    end
    conclude();
  end
endmodule // test_debug_subsys_gpio_config_regs
`default_nettype wire
